// [sim/fpr_checker.sv]
// Port checker for the power-down release and identifier block
`timescale 1ns/1ps
module fpr_checker
	import fpr_pkg::*;
#(
	parameter int unsigned RELEASE_NS    = RELEASE_DELAY_NS,
	parameter int unsigned RELEASE_ID_NS = RELEASE_WITH_ID_DELAY_NS
) (
	input wire logic                clk,
	input wire logic                resetn,
	input wire logic                spi_cs_n,
	input wire logic                spi_so_oe,
	input wire logic                write_busy_flag,
	input wire logic                power_down_reg,
	input wire logic                release_busy_reg,
	input wire logic [STATUS_W-1:0] status_reg
);
	// Slack of two cycles covers the select synchroniser
	localparam int REL_MIN = RELEASE_NS * CLK_MHZ / 1000 - 2;
	localparam int REL_MAX = RELEASE_ID_NS * CLK_MHZ / 1000 + 2;
	logic [15:0] rel_cnt_reg;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			rel_cnt_reg <= 16'h0;
		else
			rel_cnt_reg <= release_busy_reg ? rel_cnt_reg + 16'h1 : 16'h0;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence s_pd_exit;
		power_down_reg ##1 !power_down_reg;
	endsequence
	sequence s_cs_idle;
		spi_cs_n [*6];
	endsequence
	status_const_a: assert property (status_reg[23:1] == 23'h100000)
		else $error("status constant bits wrong");
	busy_mirror_a: assert property ($rose(write_busy_flag) |=> status_reg[0])
		else $error("busy bit not mirrored");
	exit_to_wait_a: assert property (s_pd_exit |=> release_busy_reg)
		else $error("no release delay after exit");
	exit_on_cs_a: assert property (s_pd_exit |-> spi_cs_n)
		else $error("exit while selected");
	no_overlap_a: assert property (!(power_down_reg && release_busy_reg))
		else $error("down and waking together");
	quiet_wait_a: assert property (release_busy_reg && $past(release_busy_reg, 3) |-> !spi_so_oe)
		else $error("output during release delay");
	wait_min_a: assert property ($fell(release_busy_reg) |-> rel_cnt_reg >= REL_MIN)
		else $error("release delay short");
	wait_max_a: assert property (release_busy_reg |-> rel_cnt_reg <= REL_MAX)
		else $error("release delay long");
	oe_in_frame_a: assert property ($rose(spi_so_oe) |-> !spi_cs_n)
		else $error("output outside frame");
	frame_end_a: assert property (s_cs_idle |-> !spi_so_oe)
		else $error("output after select rise");
	busy_discard_a: assert property (power_down_reg && write_busy_flag && $past(write_busy_flag, 8)
		|=> power_down_reg)
		else $error("release while busy");
endmodule

bind fpr_top fpr_checker #(.RELEASE_NS(RELEASE_NS), .RELEASE_ID_NS(RELEASE_ID_NS)) u_fpr_checker (
	.clk(clk), .resetn(resetn), .spi_cs_n(spi_cs_n), .spi_so_oe(spi_so_oe),
	.write_busy_flag(write_busy_flag), .power_down_reg(power_down_reg),
	.release_busy_reg(release_busy_reg), .status_reg(status_reg));

// [sim/fpr_host.sv]
// Host serial master model for the flash link
`timescale 1ns/1ps
module fpr_host (
	input wire logic clk,
	output logic     spi_cs_n,
	output logic     spi_sck,
	output logic     spi_si,
	input wire logic spi_so
);
	logic [7:0] rx_byte;
	initial begin
		spi_cs_n = 1'b1;
		spi_sck = 1'b0;
		spi_si = 1'b0;
	end
	// Released data line toggles so a stale bit never looks valid
	always @(posedge clk) begin
		if (spi_cs_n)
			spi_si <= ~spi_si;
	end
	task automatic start();
		spi_cs_n <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	// Mode 0, 160 ns period; reply bit read at the falling edge ending it
	task automatic shift(input logic [7:0] tx);
		for (int i = 7; i >= 0; i--) begin
			spi_si <= tx[i];
			repeat (4) @(posedge clk);
			spi_sck <= 1'b1;
			repeat (4) @(posedge clk);
			spi_sck <= 1'b0;
			rx_byte[i] = spi_so;
		end
	endtask
	task automatic stop(input int gap);
		repeat (4) @(posedge clk);
		spi_cs_n <= 1'b1;
		repeat (gap) @(posedge clk);
	endtask
endmodule

// [sim/tb_top.sv]
// Self-checking bench for the power-down release and identifier block
`timescale 1ns/1ps
module tb_top;
	import fpr_pkg::*;
	localparam int REL_CYC = 30;
	localparam int REL_ID_CYC = 50;
	localparam logic [7:0] DEV_ID = 8'ha5; // Arbitrary identifier
	// Signature bytes that open the parameter tables, lowest address in the low byte
	localparam logic [31:0] TBL_SIG = 32'h50444653;
	logic                clk;
	logic                resetn;
	logic                write_busy_flag;
	logic                enter_power_down;
	logic                oe_seen;
	logic                spi_cs_n;
	logic                spi_sck;
	logic                spi_si;
	logic                spi_so;
	logic                so_line;
	logic                spi_so_oe;
	logic                power_down_reg;
	logic                release_busy_reg;
	logic [STATUS_W-1:0] status_reg;
	int                  err_total;
	int                  samples_checked;
	int                  cyc;
	int                  busy_run;
	int                  busy_len;
	fpr_top #(.RELEASE_NS(600), .RELEASE_ID_NS(1000), .DEVICE_ID(DEV_ID)) u_fpr_top (
		.clk(clk), .resetn(resetn), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_si(spi_si),
		.spi_so(spi_so), .spi_so_oe(spi_so_oe), .write_busy_flag(write_busy_flag),
		.enter_power_down(enter_power_down), .power_down_reg(power_down_reg),
		.release_busy_reg(release_busy_reg), .status_reg(status_reg));
	fpr_host u_fpr_host (.clk(clk), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_si(spi_si),
		.spi_so(so_line));
	// Undriven data line has no pull: the host sees the inverse of the stale bit
	assign so_line = spi_so_oe ? spi_so : !spi_so;
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic stop_test();
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// ----------------------------------------------------------------
	// Monitor: output activity, release delay length, run limit
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (spi_so_oe)
			oe_seen <= 1'b1;
		busy_run <= release_busy_reg ? busy_run + 1 : 0;
		if (!release_busy_reg && busy_run != 0)
			busy_len <= busy_run;
		if (cyc == 20000) begin
			err_total++;
			stop_test();
		end
	end
	task automatic go_down();
		enter_power_down <= 1'b1;
		@(posedge clk);
		enter_power_down <= 1'b0;
		repeat (3) @(posedge clk);
		check("down", 1, power_down_reg);
	endtask
	task automatic id_frame(input int gap);
		u_fpr_host.start();
		u_fpr_host.shift(OP_RELEASE_AND_ID);
		repeat (3) u_fpr_host.shift(8'h00);
		u_fpr_host.shift(8'h00);
		check("id", DEV_ID, u_fpr_host.rx_byte);
		u_fpr_host.shift(8'h00);
		check("id again", DEV_ID, u_fpr_host.rx_byte);
		u_fpr_host.stop(gap);
		check("oe off", 0, spi_so_oe);
	endtask
	task automatic t_release_only();
		go_down();
		oe_seen <= 1'b0;
		u_fpr_host.start();
		u_fpr_host.shift(OP_DISCOVERABLE);
		repeat (5) u_fpr_host.shift(8'h00);
		u_fpr_host.stop(20);
		check("ignored", 1, {oe_seen, power_down_reg} == 2'b01);
		u_fpr_host.start();
		u_fpr_host.shift(OP_RELEASE_AND_ID);
		u_fpr_host.stop(REL_ID_CYC + 20);
		check("awake", 0, power_down_reg);
		check("silent", 0, oe_seen);
		check("short wait", 1, busy_len inside {[REL_CYC:REL_CYC + 1]});
	endtask
	task automatic t_busy_then_id();
		go_down();
		write_busy_flag <= 1'b1;
		u_fpr_host.start();
		u_fpr_host.shift(OP_RELEASE_AND_ID);
		u_fpr_host.stop(REL_ID_CYC + 20);
		check("kept down", 1, power_down_reg);
		check("busy bit", 1, status_reg[0]);
		write_busy_flag <= 1'b0;
		repeat (4) @(posedge clk);
		id_frame(REL_ID_CYC + 20);
		check("woken", 0, power_down_reg);
		check("long wait", 1, busy_len inside {[REL_ID_CYC:REL_ID_CYC + 1]});
	endtask
	task automatic t_param();
		u_fpr_host.start();
		u_fpr_host.shift(OP_DISCOVERABLE);
		u_fpr_host.shift(8'h00);
		u_fpr_host.shift(8'h00);
		u_fpr_host.shift(8'h10);
		u_fpr_host.shift(8'h00);
		u_fpr_host.shift(8'h00);
		check("table end", ERASED_BYTE, u_fpr_host.rx_byte);
		u_fpr_host.stop(20);
		u_fpr_host.start();
		u_fpr_host.shift(OP_DISCOVERABLE);
		repeat (4) u_fpr_host.shift(8'h00);
		u_fpr_host.shift(8'h00);
		check("table sig 0", TBL_SIG[7:0], u_fpr_host.rx_byte);
		u_fpr_host.shift(8'h00);
		check("table sig 1", TBL_SIG[15:8], u_fpr_host.rx_byte);
		u_fpr_host.stop(20);
	endtask
	task automatic t_soft_reset();
		go_down();
		u_fpr_host.start();
		u_fpr_host.shift(OP_RESET_ENABLE);
		u_fpr_host.stop(20);
		check("armed only", 1, power_down_reg);
		u_fpr_host.start();
		u_fpr_host.shift(OP_RESET);
		u_fpr_host.stop(REL_ID_CYC + 20);
		check("reset wake", 0, power_down_reg);
		check("reset wait", 1, busy_len inside {[REL_CYC:REL_CYC + 1]});
	endtask
	initial begin
		{resetn, write_busy_flag, enter_power_down, oe_seen} = 4'h0;
		{err_total, samples_checked, cyc, busy_run, busy_len} = 0;
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		repeat (5) @(posedge clk);
		check("status", 24'h200000, status_reg);
		check("reset", 0, {power_down_reg, release_busy_reg, spi_so_oe});
		id_frame(20);
		t_release_only();
		t_busy_then_id();
		t_soft_reset();
		t_param();
		stop_test();
	end
endmodule

// [verilog/fpr_param_table.sv]
// Discoverable parameter table with registered read data
`timescale 1ns/1ps
module fpr_param_table
	import fpr_pkg::*;
#(
	parameter int unsigned DEPTH = TABLE_BYTES
) (
	input  wire logic          clk,
	input  wire logic          resetn,
	fpr_table_if.table_side    tbl
);

	initial begin
		if (DEPTH < 16 || DEPTH > 256)
			$error("fpr_param_table: DEPTH out of range");
	end

	function automatic logic [7:0] table_byte(input logic [7:0] a);
		case (a)
			8'h00:   table_byte = 8'h53;
			8'h01:   table_byte = 8'h46;
			8'h02:   table_byte = 8'h44;
			8'h03:   table_byte = 8'h50;
			8'h04:   table_byte = 8'h06;
			8'h05:   table_byte = 8'h01;
			8'h06:   table_byte = 8'h00;
			8'h07:   table_byte = 8'hff;
			8'h08:   table_byte = 8'h00;
			8'h09:   table_byte = 8'h06;
			8'h0a:   table_byte = 8'h01;
			8'h0b:   table_byte = 8'h04;
			8'h0c:   table_byte = 8'h30;
			8'h0d:   table_byte = 8'h00;
			8'h0e:   table_byte = 8'h00;
			default: table_byte = ERASED_BYTE;
		endcase
	endfunction

	// Addresses past the table read as erased
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			tbl.data <= 8'hff;
		else if (tbl.addr < 24'(DEPTH))
			tbl.data <= table_byte(tbl.addr[7:0]);
		else
			tbl.data <= ERASED_BYTE;
	end

endmodule

// [verilog/fpr_pkg.sv]
// Shared constants for the power-down release and identifier block
package fpr_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_MHZ                  = 50;
	localparam int unsigned RELEASE_DELAY_NS         = 3000;
	localparam int unsigned RELEASE_WITH_ID_DELAY_NS = 8000;
	localparam int unsigned DELAY_W                  = 16;

	// ----------------------------------------------------------------
	// Opcodes
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_RELEASE_AND_ID   = 8'hab;
	localparam logic [7:0] OP_DISCOVERABLE     = 8'h5a;
	localparam logic [7:0] OP_RESET_ENABLE     = 8'h66;
	localparam logic [7:0] OP_RESET            = 8'h99;

	// ----------------------------------------------------------------
	// Frame layout, counted in bytes after the opcode
	// ----------------------------------------------------------------
	localparam logic [2:0] ID_HDR_BYTES   = 3'h3;
	localparam logic [2:0] DISC_HDR_BYTES = 3'h4;
	localparam logic [2:0] DISC_ADDR_LAST = 3'h3;

	// ----------------------------------------------------------------
	// Delivery state
	// ----------------------------------------------------------------
	localparam logic [7:0]  ERASED_BYTE         = 8'hff;
	localparam int unsigned STATUS_W            = 24;
	localparam int unsigned DRIVE_LOW_BIT_POS   = 21;
	localparam int unsigned WRITE_BUSY_BIT_POS  = 0;
	localparam logic [23:0] STATUS_DELIVERY     = 24'h200000;

	// Device identifier, value arbitrary
	localparam logic [7:0]  DEVICE_ID_DEFAULT   = 8'h5c;

	// ----------------------------------------------------------------
	// Parameter table
	// ----------------------------------------------------------------
	localparam int unsigned TABLE_ADDR_W = 24;
	localparam int unsigned TABLE_BYTES  = 16;

	typedef enum logic [4:0] {
		FR_IDLE   = 5'b00001,
		FR_OPCODE = 5'b00010,
		FR_HEADER = 5'b00100,
		FR_DATA   = 5'b01000,
		FR_IGNORE = 5'b10000
	} fpr_frame_type;

	typedef enum logic [2:0] {
		PW_ACTIVE = 3'b001,
		PW_DOWN   = 3'b010,
		PW_WAKE   = 3'b100
	} fpr_power_type;

endpackage

// [verilog/fpr_table_if.sv]
// Read path between the command logic and the parameter table
`timescale 1ns/1ps
interface fpr_table_if;
	logic [23:0] addr;
	logic [7:0]  data;

	modport requester (
		output addr,
		input  data
	);
	modport table_side (
		input  addr,
		output data
	);
endinterface

// [verilog/fpr_top.sv]
// Serial flash command logic: power-down release, identifier and parameter read
`timescale 1ns/1ps

// Overview of operation
// RULE_01 - Release opcode then select rise leaves power-down; commands refused during delay.
// RULE_02 - Host keeps select high for the whole release delay.
// RULE_03 - Opcode plus three dummy bytes gives identifier, MSB first, on falling clock.
// RULE_04 - Identifier repeats while clocked with select low; select rise ends frame.
// RULE_05 - Host keeps select high for the longer delay after release with identifier.
// RULE_06 - While write busy, the release/identifier command is discarded.
// RULE_07 - Opcode 5a returns the discoverable parameter tables.
// RULE_08 - Delivery: array reads all ones; status zero except drive strength bit 21.
// RULE_09 - In power-down only release/identifier and software reset are obeyed.
// RULE_10 - Select rising right after opcode gives a release without identifier data.
module fpr_top
	import fpr_pkg::*;
#(
	parameter int unsigned  RELEASE_NS         = RELEASE_DELAY_NS,
	parameter int unsigned  RELEASE_ID_NS      = RELEASE_WITH_ID_DELAY_NS,
	parameter logic [7:0]   DEVICE_ID          = DEVICE_ID_DEFAULT
) (
	input  wire logic                clk,
	input  wire logic                resetn,
	input  wire logic                spi_cs_n,
	input  wire logic                spi_sck,
	input  wire logic                spi_si,
	output logic                     spi_so,
	output logic                     spi_so_oe,
	input  wire logic                write_busy_flag,
	input  wire logic                enter_power_down,
	output logic                     power_down_reg,
	output logic                     release_busy_reg,
	output logic [STATUS_W-1:0]      status_reg
);

	localparam int unsigned REL_CYC    = (RELEASE_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned REL_ID_CYC = (RELEASE_ID_NS * CLK_MHZ + 999) / 1000;

	initial begin
		if (REL_CYC < 1 || REL_ID_CYC < 1 || REL_ID_CYC >= (1 << DELAY_W))
			$error("fpr_top: release delays out of range");
	end

	// ----------------------------------------------------------------
	// Pin synchronisers and edge detection
	// ----------------------------------------------------------------
	logic [1:0] cs_sync_reg;
	logic [1:0] sck_sync_reg;
	logic [1:0] si_sync_reg;
	logic       cs_d_reg;
	logic       sck_d_reg;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cs_sync_reg  <= 2'h3;
			sck_sync_reg <= 2'h0;
			si_sync_reg  <= 2'h0;
			cs_d_reg     <= 1'b1;
			sck_d_reg    <= 1'b0;
		end else begin
			cs_sync_reg  <= {cs_sync_reg[0], spi_cs_n};
			sck_sync_reg <= {sck_sync_reg[0], spi_sck};
			si_sync_reg  <= {si_sync_reg[0], spi_si};
			cs_d_reg     <= cs_sync_reg[1];
			sck_d_reg    <= sck_sync_reg[1];
		end
	end

	logic cs_low;
	logic cs_rise;
	logic sck_rise;
	logic sck_fall;
	logic si_bit;

	assign cs_low   = !cs_sync_reg[1];
	assign cs_rise  = cs_sync_reg[1] && !cs_d_reg;
	assign sck_rise = cs_low && sck_sync_reg[1] && !sck_d_reg;
	assign sck_fall = cs_low && !sck_sync_reg[1] && sck_d_reg;
	assign si_bit   = si_sync_reg[1];

	// ----------------------------------------------------------------
	// Frame decoder
	// ----------------------------------------------------------------
	fpr_frame_type frame_reg;
	fpr_power_type power_reg;
	logic [2:0]    bit_cnt_reg;
	logic [2:0]    byte_idx_reg;
	logic [7:0]    shift_in_reg;
	logic [7:0]    cmd_reg;
	logic [23:0]   addr_reg;
	logic [23:0]   data_cnt_reg;
	logic          reset_armed_reg;
	logic          reset_hit_reg;
	logic [7:0]    byte_in;
	logic          byte_done;
	logic          refuse_all;

	fpr_table_if tbl ();

	assign byte_in    = {shift_in_reg[6:0], si_bit};
	assign byte_done  = sck_rise && (bit_cnt_reg == 3'h7);
	assign refuse_all = (power_reg == PW_WAKE); // RULE_01
	assign tbl.addr   = addr_reg + data_cnt_reg;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			bit_cnt_reg  <= 3'h0;
			shift_in_reg <= 8'h00;
		end else if (!cs_low) begin
			bit_cnt_reg  <= 3'h0;
		end else if (sck_rise) begin
			bit_cnt_reg  <= bit_cnt_reg + 3'h1;
			shift_in_reg <= byte_in;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			frame_reg    <= FR_IDLE;
			cmd_reg      <= 8'h00;
			byte_idx_reg <= 3'h0;
			addr_reg     <= 24'h000000;
			data_cnt_reg <= 24'h000000;
		end else if (!cs_low) begin
			frame_reg    <= FR_IDLE;
		end else begin
			case (frame_reg)
				FR_IDLE: begin
					frame_reg    <= FR_OPCODE;
					byte_idx_reg <= 3'h0;
					addr_reg     <= 24'h000000;
					data_cnt_reg <= 24'h000000;
				end
				FR_OPCODE: if (byte_done) begin
					cmd_reg      <= byte_in;
					byte_idx_reg <= 3'h1;
					if (refuse_all)
						frame_reg <= FR_IGNORE;
					else if (byte_in == OP_RELEASE_AND_ID && !write_busy_flag)
						frame_reg <= FR_HEADER; // RULE_06
					else if (byte_in == OP_DISCOVERABLE && power_reg == PW_ACTIVE)
						frame_reg <= FR_HEADER; // RULE_07 RULE_09
					else
						frame_reg <= FR_IGNORE;
				end
				FR_HEADER: if (byte_done) begin
					byte_idx_reg <= byte_idx_reg + 3'h1;
					if (cmd_reg == OP_DISCOVERABLE && byte_idx_reg <= DISC_ADDR_LAST)
						addr_reg <= {addr_reg[15:0], byte_in};
					if (cmd_reg == OP_RELEASE_AND_ID && byte_idx_reg == ID_HDR_BYTES)
						frame_reg <= FR_DATA; // RULE_03
					if (cmd_reg == OP_DISCOVERABLE && byte_idx_reg == DISC_HDR_BYTES)
						frame_reg <= FR_DATA; // RULE_07
				end
				FR_DATA: if (byte_done && cmd_reg == OP_DISCOVERABLE)
					data_cnt_reg <= data_cnt_reg + 24'h000001;
				FR_IGNORE: frame_reg <= FR_IGNORE;
				default:   frame_reg <= FR_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Serial output, changed on falling clock edges
	// ----------------------------------------------------------------
	logic [7:0] out_byte;

	assign out_byte = (cmd_reg == OP_RELEASE_AND_ID) ? DEVICE_ID : tbl.data;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			spi_so    <= 1'b0;
			spi_so_oe <= 1'b0;
		end else if (!cs_low) begin
			spi_so_oe <= 1'b0; // RULE_04
		end else if (sck_fall && frame_reg == FR_DATA) begin
			// Identifier repeats because the byte source never advances
			spi_so    <= out_byte[3'h7 - bit_cnt_reg]; // RULE_03 RULE_04
			spi_so_oe <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Software reset pair, the only other command obeyed in power-down
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			reset_armed_reg <= 1'b0;
			reset_hit_reg   <= 1'b0;
		end else if (cs_rise) begin
			reset_hit_reg <= 1'b0;
		end else if (frame_reg == FR_OPCODE && byte_done && !refuse_all) begin
			reset_armed_reg <= (byte_in == OP_RESET_ENABLE);
			reset_hit_reg   <= reset_armed_reg && (byte_in == OP_RESET); // RULE_09
		end
	end

	// ----------------------------------------------------------------
	// Power state and release delay
	// ----------------------------------------------------------------
	logic [DELAY_W-1:0] wake_cnt_reg;
	logic               release_only;
	logic               release_id;

	// Any bit past the opcode without reaching data releases nothing
	assign release_only = frame_reg == FR_HEADER && byte_idx_reg == 3'h1 && bit_cnt_reg == 3'h0;
	assign release_id   = frame_reg == FR_DATA && cmd_reg == OP_RELEASE_AND_ID;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			power_reg    <= PW_ACTIVE;
			wake_cnt_reg <= '0;
		end else begin
			case (power_reg)
				PW_ACTIVE: if (enter_power_down && !write_busy_flag && !cs_low)
					power_reg <= PW_DOWN;
				PW_DOWN: if (cs_rise && (reset_hit_reg || release_only)) begin
					power_reg    <= PW_WAKE; // RULE_01 RULE_10
					wake_cnt_reg <= DELAY_W'(REL_CYC - 1);
				end else if (cs_rise && release_id) begin
					power_reg    <= PW_WAKE;
					wake_cnt_reg <= DELAY_W'(REL_ID_CYC - 1);
				end
				PW_WAKE: if (wake_cnt_reg == '0)
					power_reg <= PW_ACTIVE;
				else
					wake_cnt_reg <= wake_cnt_reg - 1'b1; // RULE_01
				default: power_reg <= PW_ACTIVE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Status view and power flags
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			status_reg       <= STATUS_DELIVERY; // RULE_08
			power_down_reg   <= 1'b0;
			release_busy_reg <= 1'b0;
		end else begin
			status_reg[WRITE_BUSY_BIT_POS] <= write_busy_flag;
			power_down_reg   <= (power_reg == PW_DOWN);
			release_busy_reg <= (power_reg == PW_WAKE);
		end
	end

	fpr_param_table #(
		.DEPTH (TABLE_BYTES)
	) u_table (
		.clk    (clk),
		.resetn (resetn),
		.tbl    (tbl)
	);

endmodule
